// *** include/dmem_defs.svh ***
`ifndef DMEM_DEFS_SVH
`define DMEM_DEFS_SVH
// data memory map
`define ADDR_INDIRECT_PORT_A 8'h00
`define ADDR_POINTER_A 8'h01
`define ADDR_INDIRECT_PORT_B 8'h02
`define ADDR_POINTER_B 8'h03
`define ADDR_WORK_REG 8'h05
`define ADDR_GP_BASE 8'h60
`define GP_BANK_WORDS 8'ha0
`define GP_INDEX_W 8
`define RESET_POINTER 8'h00
`define RESET_WORK_REG 8'h00
`define RO_MASK_WORK_REG 8'h00
`define BIT_LOCK_WORK_REG 8'h00
`endif

// *** include/dmem_pkg.sv ***
`default_nettype none
package dmem_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_READ = 3'b001,
    OP_WRITE = 3'b010,
    OP_BSET = 3'b011,
    OP_BCLR = 3'b100,
    OP_ALU = 3'b101
  } mem_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RMW = 2'b01
  } rmw_state_t;
endpackage : dmem_pkg
`default_nettype wire

// *** src/gp_ram.sv ***
`default_nettype none
module gp_ram (
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [8:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:511];
  // ---------------------------------------------------------------
  // storage, registered read
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[addr] <= wr_data;
      end
      rd_data <= mem[addr];
    end
  end
endmodule : gp_ram
`default_nettype wire

// *** src/data_memory_indirect_access.sv ***
// Overview of operation
// - byte-wide memory from 00H, special area then general area, no gap
// - every general-purpose location is readable and writable
// - unused or reserved special-function addresses read as zero
// - read-only special-function bits ignore program writes
// - single-bit set and clear work; no bits are locked, the lock masks are zero
// - access to an indirect port goes to its pointer's location
// - port a reaches bank 0 only; port b reaches banks 0 and 1
// - pointer aimed at an indirect port reads zero, writes nothing
// - both pointers are real registers, read, written and bit-manipulated
// - work register takes the alu result
// - no register-to-register move; one location per operation
// - special registers sit at fixed addresses from 00H
`include "dmem_defs.svh"
`default_nettype none
module data_memory_indirect_access (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire dmem_pkg::mem_op_t op,
  input wire logic [7:0] addr,
  input wire logic bank_sel,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] alu_result,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output logic [7:0] work_reg_out
);
  import dmem_pkg::*;

  logic [7:0] pointer_a;
  logic [7:0] pointer_b;
  logic [7:0] work_reg;
  rmw_state_t state;
  logic [7:0] eff_addr;
  logic eff_bank;
  logic via_port;
  logic to_port;
  logic is_gp;
  logic [8:0] ram_addr;
  logic [7:0] ram_rd;
  logic ram_we;
  logic [7:0] ram_wd;
  logic [7:0] hold_addr;
  logic hold_bank;
  logic hold_set;
  logic [2:0] hold_bit;
  logic [7:0] mask;
  logic [7:0] sfr_rd;
  logic read_gp_q;
  logic read_sfr_q;
  logic [7:0] sfr_q;
  logic accept;

  assign accept = clk_en && state == ST_IDLE;

  // ---------------------------------------------------------------
  // address resolution
  // ---------------------------------------------------------------
  always_comb begin
    via_port = 1'b0;
    eff_addr = addr;
    eff_bank = 1'b0;
    if (addr == `ADDR_INDIRECT_PORT_A) begin
      via_port = 1'b1;
      eff_addr = pointer_a;
      eff_bank = 1'b0;
    end else if (addr == `ADDR_INDIRECT_PORT_B) begin
      via_port = 1'b1;
      eff_addr = pointer_b;
      eff_bank = bank_sel;
    end
    if (state == ST_RMW) begin
      eff_addr = hold_addr;
      eff_bank = hold_bank;
    end
  end

  assign to_port = via_port && (eff_addr == `ADDR_INDIRECT_PORT_A ||
                   eff_addr == `ADDR_INDIRECT_PORT_B);
  assign is_gp = eff_addr >= `ADDR_GP_BASE;
  assign ram_addr = {eff_bank, eff_addr - `ADDR_GP_BASE};
  assign mask = 8'h01 << hold_bit;

  // ---------------------------------------------------------------
  // special-function read mux
  // ---------------------------------------------------------------
  always_comb begin
    case (eff_addr)
      `ADDR_POINTER_A: sfr_rd = pointer_a;
      `ADDR_POINTER_B: sfr_rd = pointer_b;
      `ADDR_WORK_REG: sfr_rd = work_reg;
      default: sfr_rd = 8'h00;
    endcase
    if (to_port) begin
      sfr_rd = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // general-purpose ram write path
  // ---------------------------------------------------------------
  always_comb begin
    ram_we = 1'b0;
    ram_wd = wr_data;
    if (clk_en && is_gp) begin
      if (state == ST_RMW) begin
        ram_we = 1'b1;
        ram_wd = hold_set ? (ram_rd | mask) : (ram_rd & ~mask);
      end else if (op == OP_WRITE && !to_port) begin
        ram_we = 1'b1;
      end
    end
  end

  gp_ram u_ram (
    .ref_clk(ref_clk),
    .clk_en(clk_en),
    .wr_en(ram_we),
    .addr(ram_addr),
    .wr_data(ram_wd),
    .rd_data(ram_rd)
  );

  // ---------------------------------------------------------------
  // bit operation sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      hold_addr <= 8'h00;
      hold_bank <= 1'b0;
      hold_set <= 1'b0;
      hold_bit <= 3'h0;
    end else if (clk_en) begin
      case (state)
        ST_IDLE: begin
          if ((op == OP_BSET || op == OP_BCLR) && is_gp && !to_port) begin
            state <= ST_RMW;
            hold_addr <= eff_addr;
            hold_bank <= eff_bank;
            hold_set <= op == OP_BSET;
            hold_bit <= bit_sel;
          end
        end
        ST_RMW: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // special-function registers
  // ---------------------------------------------------------------
  function automatic logic [7:0] upd(input logic [7:0] cur, input mem_op_t o,
                                     input logic [7:0] d, input logic [2:0] b,
                                     input logic [7:0] lock);
    logic [7:0] m;
    m = (8'h01 << b) & ~lock;
    case (o)
      OP_WRITE: upd = d;
      OP_BSET: upd = cur | m;
      OP_BCLR: upd = cur & ~m;
      default: upd = cur;
    endcase
  endfunction : upd

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pointer_a <= `RESET_POINTER;
      pointer_b <= `RESET_POINTER;
    end else if (accept && !to_port) begin
      if (eff_addr == `ADDR_POINTER_A) begin
        pointer_a <= upd(pointer_a, op, wr_data, bit_sel, 8'h00);
      end
      if (eff_addr == `ADDR_POINTER_B) begin
        pointer_b <= upd(pointer_b, op, wr_data, bit_sel, 8'h00);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_reg <= `RESET_WORK_REG;
    end else if (accept) begin
      if (op == OP_ALU) begin
        work_reg <= alu_result;
      end else if (!to_port && eff_addr == `ADDR_WORK_REG) begin
        work_reg <= (upd(work_reg, op, wr_data, bit_sel, `BIT_LOCK_WORK_REG)
                     & ~`RO_MASK_WORK_REG) | (work_reg & `RO_MASK_WORK_REG);
      end
    end
  end

  // ---------------------------------------------------------------
  // read decode, one cycle after the request
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_gp_q <= 1'b0;
      read_sfr_q <= 1'b0;
      sfr_q <= 8'h00;
    end else if (clk_en) begin
      read_gp_q <= accept && op == OP_READ && is_gp && !to_port;
      read_sfr_q <= accept && op == OP_READ && !(is_gp && !to_port);
      sfr_q <= sfr_rd;
    end
  end

  // ---------------------------------------------------------------
  // read answer register, two cycles after the request
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= read_gp_q || read_sfr_q;
      rd_data <= read_gp_q ? ram_rd : (read_sfr_q ? sfr_q : 8'h00);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      work_reg_out <= 8'h00;
    end else if (clk_en) begin
      busy <= accept && (op == OP_BSET || op == OP_BCLR) && is_gp && !to_port;
      work_reg_out <= (accept && op == OP_ALU) ? alu_result : work_reg;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_alu_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_ALU |=> work_reg == $past(alu_result))
    else $error("work register missed alu result");
  chk_port_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_READ && to_port |-> ##2 rd_valid && rd_data == 8'h00)
    else $error("self-pointing indirect read not zero");
  chk_unused_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_READ && !via_port && addr == 8'h04
    |-> ##2 rd_data == 8'h00)
    else $error("unused address read not zero");
  chk_rmw_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_RMW |=> state == ST_IDLE)
    else $error("bit operation not finished in two cycles");
  chk_ptr_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_WRITE && addr == `ADDR_POINTER_A
    |=> pointer_a == $past(wr_data))
    else $error("pointer a write lost");
  chk_bank_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_IDLE && addr == `ADDR_INDIRECT_PORT_A |-> !ram_addr[8])
    else $error("port a left bank 0");
  chk_gp_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_READ && is_gp && !to_port |-> ##2 rd_valid)
    else $error("general read not answered");
  chk_ram_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_WRITE && via_port && is_gp && !to_port
    |-> ram_we)
    else $error("indirect write not sent to ram");
  chk_ptr_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_WRITE && addr == `ADDR_WORK_REG
    |=> pointer_b == $past(pointer_b))
    else $error("write touched a second register");
  chk_busy_rmw: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && (op == OP_BSET || op == OP_BCLR) && is_gp && !to_port
    |=> busy && state == ST_RMW)
    else $error("ram bit operation did not enter its write cycle");
  chk_rmw_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_RMW |-> ram_we)
    else $error("bit operation write-back missing");
  chk_port_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_WRITE && to_port
    |-> !ram_we ##1 (pointer_a == $past(pointer_a) && pointer_b == $past(pointer_b)))
    else $error("self-pointing indirect write changed storage");
  chk_bank_b: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && addr == `ADDR_INDIRECT_PORT_B && pointer_b >= `ADDR_GP_BASE
    |-> ram_addr[8] == bank_sel)
    else $error("port b missed the selected bank");
  chk_ptr_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_READ && addr == `ADDR_POINTER_B
    |-> ##2 rd_valid && rd_data == $past(pointer_b, 2))
    else $error("pointer b read back wrong");
  chk_work_ro: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_WRITE && addr == `ADDR_WORK_REG
    |=> (work_reg & `RO_MASK_WORK_REG) == ($past(work_reg) & `RO_MASK_WORK_REG))
    else $error("read-only work register bits changed");
  chk_alu_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_ALU |=> work_reg_out == $past(alu_result))
    else $error("work register copy missed alu result");
  chk_gp_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state == ST_IDLE && op == OP_WRITE && !via_port && is_gp
    |-> ram_we && ram_wd == wr_data)
    else $error("direct general write not sent to ram");
endmodule : data_memory_indirect_access
`default_nettype wire

// *** test/core_model.sv ***
`default_nettype none
module core_model (
  input wire logic ref_clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic busy,
  output var dmem_pkg::mem_op_t op,
  output logic [7:0] addr,
  output logic bank_sel,
  output logic [7:0] wr_data,
  output logic [2:0] bit_sel,
  output logic [7:0] alu_result
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmem_pkg::*;
  logic seen_busy = 1'b0;
  initial begin
    op = OP_NONE;
    addr = 8'h00;
    bank_sel = 1'b0;
    wr_data = 8'h00;
    bit_sel = 3'h0;
    alu_result = 8'h00;
  end
  // ------------------------------------------------------------
  // one request, taken at the next edge, then one idle cycle
  // ------------------------------------------------------------
  task automatic issue(input mem_op_t o, input logic [7:0] a, input logic [7:0] d,
                       input logic [2:0] b, input logic bk, output logic [7:0] q,
                       output logic v);
    @(posedge ref_clk);
    op <= o;
    addr <= a;
    wr_data <= d;
    bit_sel <= b;
    bank_sel <= bk;
    alu_result <= d;
    @(posedge ref_clk);
    op <= OP_NONE;
    addr <= ~a;
    wr_data <= ~d;
    alu_result <= ~d;
    #1;
    seen_busy = busy;
    @(posedge ref_clk);
    #1;
    q = rd_data;
    v = rd_valid;
  endtask : issue
endmodule : core_model
`default_nettype wire

// *** test/data_memory_indirect_access_test.sv ***
`include "dmem_defs.svh"
`default_nettype none
module data_memory_indirect_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dmem_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  mem_op_t op;
  logic [7:0] addr, wr_data, alu_result, rd_data, work_reg_out;
  logic bank_sel, rd_valid, busy;
  logic [2:0] bit_sel;
  int failures = 0;
  int tests_run = 0;
  core_model core (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
    .op(op), .addr(addr), .bank_sel(bank_sel), .wr_data(wr_data), .bit_sel(bit_sel),
    .alu_result(alu_result));
  data_memory_indirect_access DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .op(op), .addr(addr), .bank_sel(bank_sel), .wr_data(wr_data), .bit_sel(bit_sel),
    .alu_result(alu_result), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
    .work_reg_out(work_reg_out));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic bk, input logic [7:0] exp,
                    input string name);
    logic [7:0] q;
    logic v;
    core.issue(OP_READ, a, 8'h00, 3'h0, bk, q, v);
    check({name, " valid"}, {7'h00, v}, 8'h01);
    check(name, q, exp);
  endtask : rd
  task automatic put(input mem_op_t o, input logic [7:0] a, input logic [7:0] d,
                     input logic [2:0] b, input logic bk);
    logic [7:0] q;
    logic v;
    core.issue(o, a, d, b, bk, q, v);
  endtask : put
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check("work_reg_out", work_reg_out, 8'h00);
    rd(`ADDR_POINTER_A, 1'b0, `RESET_POINTER, "pointer_a");
    rd(`ADDR_POINTER_B, 1'b0, `RESET_POINTER, "pointer_b");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_ram();
    put(OP_WRITE, `ADDR_GP_BASE, 8'ha5, 3'h0, 1'b0);
    put(OP_WRITE, 8'hff, 8'h5a, 3'h0, 1'b0);
    rd(`ADDR_GP_BASE, 1'b0, 8'ha5, "ram first");
    rd(8'hff, 1'b0, 8'h5a, "ram last");
    $display("t_ram done");
  endtask : t_ram
  task automatic t_unmapped();
    put(OP_WRITE, 8'h04, 8'hff, 3'h0, 1'b0);
    put(OP_WRITE, 8'h4a, 8'hff, 3'h0, 1'b0);
    put(OP_WRITE, 8'h5f, 8'hff, 3'h0, 1'b0);
    rd(8'h04, 1'b0, 8'h00, "sfr 04");
    rd(8'h4a, 1'b0, 8'h00, "sfr 4a");
    rd(8'h5f, 1'b0, 8'h00, "gap 5f");
    $display("t_unmapped done");
  endtask : t_unmapped
  task automatic t_work();
    put(OP_WRITE, `ADDR_WORK_REG, 8'h3c, 3'h0, 1'b0);
    rd(`ADDR_WORK_REG, 1'b0, 8'h3c & ~`RO_MASK_WORK_REG, "work_reg");
    put(OP_ALU, 8'h00, 8'hc3, 3'h0, 1'b0);
    check("alu work_reg_out", work_reg_out, 8'hc3);
    rd(`ADDR_WORK_REG, 1'b0, 8'hc3, "alu work_reg");
    put(OP_WRITE, 8'h61, 8'h77, 3'h0, 1'b0);
    check("work_reg kept", work_reg_out, 8'hc3);
    rd(8'h61, 1'b0, 8'h77, "ram 61");
    $display("t_work done");
  endtask : t_work
  task automatic t_indirect();
    put(OP_WRITE, `ADDR_POINTER_A, 8'h62, 3'h0, 1'b0);
    put(OP_WRITE, `ADDR_INDIRECT_PORT_A, 8'h11, 3'h0, 1'b0);
    rd(8'h62, 1'b0, 8'h11, "port a target");
    rd(`ADDR_POINTER_A, 1'b0, 8'h62, "pointer_a kept");
    put(OP_WRITE, `ADDR_POINTER_B, 8'h62, 3'h0, 1'b0);
    put(OP_WRITE, `ADDR_INDIRECT_PORT_B, 8'h22, 3'h0, 1'b1);
    rd(8'h62, 1'b0, 8'h11, "bank 0 untouched");
    rd(`ADDR_INDIRECT_PORT_B, 1'b1, 8'h22, "port b bank 1");
    rd(`ADDR_INDIRECT_PORT_B, 1'b0, 8'h11, "port b bank 0");
    rd(`ADDR_INDIRECT_PORT_A, 1'b1, 8'h11, "port a bank 0 only");
    $display("t_indirect done");
  endtask : t_indirect
  task automatic t_self();
    put(OP_WRITE, `ADDR_POINTER_A, `ADDR_INDIRECT_PORT_B, 3'h0, 1'b0);
    put(OP_WRITE, `ADDR_INDIRECT_PORT_A, 8'h99, 3'h0, 1'b0);
    rd(`ADDR_INDIRECT_PORT_A, 1'b0, 8'h00, "port a on port");
    rd(`ADDR_POINTER_B, 1'b0, 8'h62, "pointer_b kept");
    $display("t_self done");
  endtask : t_self
  task automatic t_bits();
    put(OP_BSET, `ADDR_INDIRECT_PORT_B, 8'h00, 3'h7, 1'b0);
    check("busy ram bit", {7'h00, core.seen_busy}, 8'h01);
    rd(8'h62, 1'b0, 8'h91, "bset via port");
    put(OP_BCLR, `ADDR_INDIRECT_PORT_B, 8'h00, 3'h0, 1'b0);
    rd(8'h62, 1'b0, 8'h90, "bclr via port");
    put(OP_BSET, `ADDR_POINTER_A, 8'h00, 3'h4, 1'b0);
    check("busy sfr bit", {7'h00, core.seen_busy}, 8'h00);
    rd(`ADDR_POINTER_A, 1'b0, 8'h12, "bset pointer_a");
    put(OP_BCLR, `ADDR_GP_BASE, 8'h00, 3'h0, 1'b0);
    rd(`ADDR_GP_BASE, 1'b0, 8'ha4, "bclr ram");
    rd(8'h61, 1'b0, 8'h77, "neighbour kept");
    $display("t_bits done");
  endtask : t_bits
  task automatic t_freeze();
    @(posedge ref_clk);
    clk_en <= 1'b0;
    put(OP_WRITE, 8'h61, 8'hee, 3'h0, 1'b0);
    put(OP_ALU, 8'h00, 8'h5e, 3'h0, 1'b0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(8'h61, 1'b0, 8'h77, "frozen write");
    check("frozen alu", work_reg_out, 8'hc3);
    $display("t_freeze done");
  endtask : t_freeze
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_ram();
    t_unmapped();
    t_work();
    t_indirect();
    t_self();
    t_bits();
    t_freeze();
    complete_run();
  end
  initial begin
    #20000;
    failures++;
    complete_run();
  end
endmodule : data_memory_indirect_access_test
`default_nettype wire
